// file: rtl/protection_alarm_trip_aggregator.v
// Purpose: collective alarm, trip and breaker request frame of a relay
// Assumes: element criteria arrive asynchronously; one clock aclk
// Notes: read map at 0x00..0x1c, write map at 0x00..0x0c
//   trip_delay is not synchronised; change it with protection inactive
//
// How it works
// - inactive protection suppresses every alarm, trip and command output
// - blocked frame makes every element ineffective
// - external block needs permit; input b optional
// - block lasts while any block input true
// - permanent block withholds trip commands only
// - permitted trip block input withholds commands
// - supervision-only elements stay local, no command
// - element alarm follows its fault criterion
// - element trip after its delay elapses
// - general alarm ORs non-supervision element alarms
// - general trip ORs non-supervision element trips
// - element command needs trip, no block
// - phase outputs only from capable elements
// - each phase ORs alarms and trips concerning it
// - module block needs permit and assigned input
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "prot_frame_map.vh"
module protection_alarm_trip_aggregator #(
   parameter ELEMENTS = 8,
   parameter DELAY_WIDTH = 16,
   parameter PHASES = 3
) (
   input wire aclk, // system clock
   input wire aresetn, // synchronous reset, low
   input wire [ELEMENTS-1:0] fault_criterion, // element fault seen
   input wire [ELEMENTS*PHASES-1:0] fault_phase, // per-phase criterion
   input wire [ELEMENTS*DELAY_WIDTH-1:0] trip_delay, // cycles per element
   input wire block_input_a, // assigned blocking signal
   input wire block_input_b, // optional blocking signal
   input wire block_input_b_assigned, // b has a signal
   input wire trip_block_input, // trip command block signal
   input wire [31:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output reg s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // byte enables
   input wire s_axi_wvalid, // write data valid
   output reg s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [31:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output reg s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   output reg general_alarm, // collective alarm
   output reg general_trip, // collective trip
   output reg [PHASES-1:0] phase_alarm, // phase_one first
   output reg [PHASES-1:0] phase_trip, // phase_one first
   output reg [ELEMENTS-1:0] element_alarm, // element-local alarm
   output reg [ELEMENTS-1:0] element_trip, // element-local trip
   output reg [ELEMENTS-1:0] breaker_open_request // per element command
);

////////////////////////////////////////////////////////////////////////
// synchronisers
// two flops per pin cost two cycles of pickup latency
reg [ELEMENTS-1:0] crit_meta, crit;
reg [ELEMENTS*PHASES-1:0] ph_meta, ph;
reg [2:0] blk_meta, blk;
always @(posedge aclk) begin
   if (!aresetn) begin
      crit_meta <= {ELEMENTS{1'b0}};
      crit <= {ELEMENTS{1'b0}};
      ph_meta <= {ELEMENTS*PHASES{1'b0}};
      ph <= {ELEMENTS*PHASES{1'b0}};
      blk_meta <= 3'h0;
      blk <= 3'h0;
   end else begin
      crit_meta <= fault_criterion;
      crit <= crit_meta;
      ph_meta <= fault_phase;
      ph <= ph_meta;
      blk_meta <= {trip_block_input, block_input_b, block_input_a};
      blk <= blk_meta;
   end
end

////////////////////////////////////////////////////////////////////////
// registers
reg [`CTRL_WIDTH-1:0] ctrl;
reg [ELEMENTS-1:0] superv_only;
reg [ELEMENTS-1:0] phase_capable;
reg [ELEMENTS-1:0] elem_perm_block;
reg [31:0] aw_addr;
reg aw_held, w_held;
reg [31:0] w_data;
wire prot_active = ctrl[`CTRL_PROT_ACTIVE];
// assignment of b is a static strap, read unsynchronised
// permit gates block
wire frame_blocked = ctrl[`CTRL_EXT_BLOCK_PERMIT] &
   (blk[0] | (blk[1] & block_input_b_assigned));
wire cmd_blocked = ctrl[`CTRL_TRIP_PERM_BLOCK] |
   (ctrl[`CTRL_EXT_TRIP_PERMIT] & blk[2]);
wire effective = prot_active & ~frame_blocked;

function [31:0] pad;
   input [ELEMENTS-1:0] v;
   begin
      pad = 32'h0;
      pad[ELEMENTS-1:0] = v;
   end
endfunction

// address decode, one function each for the write and read channels
function wr_in_map;
   input [31:0] a;
   begin
      wr_in_map = (a[31:`MAP_SPAN_BITS] == {(32-`MAP_SPAN_BITS){1'b0}});
   end
endfunction

function rd_in_map;
   input [31:0] a;
   begin
      rd_in_map = (a[31:`MAP_SPAN_BITS+1] ==
         {(31-`MAP_SPAN_BITS){1'b0}});
   end
endfunction

// upper half of the read map shows live state, lower half settings
function rd_status_half;
   input [31:0] a;
   begin
      rd_status_half = a[`MAP_SPAN_BITS];
   end
endfunction

always @(posedge aclk) begin
   if (!aresetn) begin
      ctrl <= `CTRL_RESET;
      superv_only <= {ELEMENTS{1'b0}};
      phase_capable <= {ELEMENTS{1'b0}};
      elem_perm_block <= {ELEMENTS{1'b0}};
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
   end else begin
      // ready waits for no valid, so a master may raise valid at will
      s_axi_awready <= ~aw_held & ~s_axi_bvalid;
      s_axi_wready <= ~w_held & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         s_axi_wready <= 1'b0;
      end
      if (aw_held & w_held & ~s_axi_bvalid) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_in_map(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         // strobes ignored: software always writes whole words
         if (wr_in_map(aw_addr))
            case (aw_addr[`MAP_SPAN_BITS-1:0])
               `OFS_CTRL: ctrl <= w_data[`CTRL_WIDTH-1:0];
               `OFS_SUPERV: superv_only <= w_data[ELEMENTS-1:0];
               `OFS_PHASE_CAP: phase_capable <= w_data[ELEMENTS-1:0];
               `OFS_PERM_BLOCK: elem_perm_block <= w_data[ELEMENTS-1:0];
               default: ctrl <= ctrl;
            endcase
      end
      if (s_axi_bvalid & s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// read channel
always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
   end else begin
      // idle ready toggles; a request waits at most one extra cycle
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid & s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h0;
         if (!rd_in_map(s_axi_araddr))
            s_axi_rresp <= `RESP_SLVERR;
         else if (!rd_status_half(s_axi_araddr))
            case (s_axi_araddr[`MAP_SPAN_BITS-1:0])
               `OFS_CTRL: s_axi_rdata <= {28'h0, ctrl};
               `OFS_SUPERV: s_axi_rdata <= pad(superv_only);
               `OFS_PHASE_CAP: s_axi_rdata <= pad(phase_capable);
               `OFS_PERM_BLOCK: s_axi_rdata <= pad(elem_perm_block);
               default: s_axi_rresp <= `RESP_SLVERR;
            endcase
         else
            case (s_axi_araddr[`MAP_SPAN_BITS-1:0])
               `OFS_STATUS: s_axi_rdata <= {24'h0, phase_trip[2:0],
                  general_trip, general_alarm, cmd_blocked,
                  frame_blocked, effective};
               `OFS_ALARM_STAT: s_axi_rdata <= pad(element_alarm);
               `OFS_TRIP_STAT: s_axi_rdata <= pad(element_trip);
               `OFS_CMD_STAT: s_axi_rdata <= pad(breaker_open_request);
               default: s_axi_rresp <= `RESP_SLVERR;
            endcase
      end
      if (s_axi_rvalid & s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// element timers and collective outputs
reg [DELAY_WIDTH-1:0] timer [0:ELEMENTS-1];
reg [ELEMENTS-1:0] elapsed;
reg [ELEMENTS-1:0] contrib;
reg [PHASES-1:0] next_pa, next_pt;
integer i, p, j;
// trips as the elements raise them, then as the frame collects them
wire [ELEMENTS-1:0] trip_now = elapsed & crit;
wire [ELEMENTS-1:0] trip_to_frame = trip_now & contrib;
always @* begin
   contrib = ~superv_only;
   next_pa = {PHASES{1'b0}};
   next_pt = {PHASES{1'b0}};
   for (i = 0; i < ELEMENTS; i = i + 1)
      for (p = 0; p < PHASES; p = p + 1) begin
         if (contrib[i] & phase_capable[i] & crit[i] &
               ph[i*PHASES+p])
            next_pa[p] = next_pa[p] | 1'b1;
         if (contrib[i] & phase_capable[i] & trip_now[i] &
               ph[i*PHASES+p])
            next_pt[p] = next_pt[p] | 1'b1;
      end
end

always @(posedge aclk) begin
   if (!aresetn) begin
      for (j = 0; j < ELEMENTS; j = j + 1)
         timer[j] <= {DELAY_WIDTH{1'b0}};
      elapsed <= {ELEMENTS{1'b0}};
      element_alarm <= {ELEMENTS{1'b0}};
      element_trip <= {ELEMENTS{1'b0}};
      breaker_open_request <= {ELEMENTS{1'b0}};
      general_alarm <= 1'b0;
      general_trip <= 1'b0;
      phase_alarm <= {PHASES{1'b0}};
      phase_trip <= {PHASES{1'b0}};
   end else begin
      for (j = 0; j < ELEMENTS; j = j + 1) begin
         // a zero delay still costs the registered elapsed flag a cycle
         // trip only once the delay ran out with fault still seen
         if (!crit[j] || !effective) begin
            timer[j] <= {DELAY_WIDTH{1'b0}};
            elapsed[j] <= 1'b0;
         end else if (timer[j] >= trip_delay[j*DELAY_WIDTH +:
               DELAY_WIDTH])
            elapsed[j] <= 1'b1;
         else
            timer[j] <= timer[j] + 1'b1;
      end
      element_alarm <= effective ? crit : {ELEMENTS{1'b0}};
      element_trip <= trip_now & {ELEMENTS{effective}};
      general_alarm <= effective & |(crit & contrib);
      general_trip <= effective & |trip_to_frame;
      breaker_open_request <= (effective & ~cmd_blocked &
         |trip_to_frame) ? (trip_to_frame & ~elem_perm_block) :
         {ELEMENTS{1'b0}};
      phase_alarm <= effective ? next_pa : {PHASES{1'b0}};
      phase_trip <= effective ? next_pt : {PHASES{1'b0}};
   end
end

endmodule

// file: rtl/prot_frame_map.vh
// Purpose: register map and field positions of the protection frame
// Assumes: 32-bit AXI4-Lite data, byte addresses on aligned words
// Notes: definitions only
`ifndef PROT_FRAME_MAP_VH
`define PROT_FRAME_MAP_VH
`define OFS_CTRL 4'h0
`define OFS_SUPERV 4'h4
`define OFS_PHASE_CAP 4'h8
`define OFS_PERM_BLOCK 4'hc
`define OFS_STATUS 4'h0
`define OFS_ALARM_STAT 4'h4
`define OFS_TRIP_STAT 4'h8
`define OFS_CMD_STAT 4'hc
`define CTRL_PROT_ACTIVE 0
`define CTRL_EXT_BLOCK_PERMIT 1
`define CTRL_TRIP_PERM_BLOCK 2
`define CTRL_EXT_TRIP_PERMIT 3
`define CTRL_WIDTH 4
`define CTRL_RESET 4'h0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define READ_BASE 5'h10
`define MAP_SPAN_BITS 4
`endif

// file: test/prot_far_side.sv
// Purpose: protective elements feeding fault criteria to the frame
// Assumes: bench sets the wanted fault pattern
// Notes: one cycle of element pickup, then steady levels
`timescale 1ns/100ps
module prot_far_side #(
   parameter ELEMENTS = 8,
   parameter PHASES = 3
) (
   input logic aclk, // clock
   input logic [ELEMENTS-1:0] fault_set, // wanted faults
   input logic [ELEMENTS*PHASES-1:0] phase_set, // wanted phases
   output logic [ELEMENTS-1:0] fault_criterion = '0, // to frame
   output logic [ELEMENTS*PHASES-1:0] fault_phase = '0 // to frame
);
   // levels move just after an edge, never on the sampling instant
   always @(posedge aclk) begin
      fault_criterion <= fault_set;
      fault_phase <= phase_set;
   end
endmodule

// file: test/prot_frame_asserts.sv
// Purpose: relations between the collective outputs
// Assumes: top ports only, one clock domain
// Notes: bound from the bench top file
`timescale 1ns/100ps
module prot_frame_asserts #(
   parameter ELEMENTS = 8,
   parameter PHASES = 3
) (
   input logic aclk, // clock
   input logic aresetn, // reset, low
   input logic general_alarm, // collective alarm
   input logic general_trip, // collective trip
   input logic [PHASES-1:0] phase_alarm, // per phase
   input logic [PHASES-1:0] phase_trip, // per phase
   input logic [ELEMENTS-1:0] element_alarm, // local alarms
   input logic [ELEMENTS-1:0] element_trip, // local trips
   input logic [ELEMENTS-1:0] breaker_open_request // commands
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   //////////////////////////////////////////////////////////
   AST_GA_SRC: assert property (general_alarm |-> |element_alarm)
      else $error("general alarm without element alarm");
   AST_GT_SRC: assert property (general_trip |-> |element_trip)
      else $error("general trip without element trip");
   AST_CMD_GT: assert property (|breaker_open_request |-> general_trip)
      else $error("command without general trip");
   AST_CMD_EL: assert property ((breaker_open_request & ~element_trip) == 0)
      else $error("command from an element not tripped");
   AST_PA_GA: assert property (|phase_alarm |-> general_alarm)
      else $error("phase alarm without general alarm");
   AST_PT_GT: assert property (|phase_trip |-> general_trip)
      else $error("phase trip without general trip");
   AST_TRIP_LATE: assert property ((element_trip & ~$past(element_trip)
      & ~$past(element_alarm)) == 0)
      else $error("trip rose with no alarm before it");
   AST_RST_CLR: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> !general_alarm && !general_trip && !(|breaker_open_request))
      else $error("outputs not cleared by reset");
   cover property (general_alarm && !general_trip);
   cover property (|breaker_open_request);
   cover property (|phase_trip);
endmodule

// file: test/test_protection_alarm_trip_aggregator.sv
// Purpose: self-checking bench of the protection frame
// Assumes: every element delay is four cycles
// Notes: far side model feeds the fault criteria
`timescale 1ns/100ps
module test_protection_alarm_trip_aggregator;
   localparam E = 8;
   logic aclk = 0, aresetn = 0, ba = 0, bb = 0, bas = 0, tb = 0;
   logic [E-1:0] fault_set = 0, fc, ea, et, cmd;
   logic [3*E-1:0] phase_set = 0, fp;
   logic [31:0] awa = 0, wd = 0, ara = 0, rdat, obs;
   logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ga, gt;
   logic awr, wrd, bv, arr, rv;
   logic [3:0] strb = 4'hf;
   logic [2:0] pa, pt;
   logic [1:0] br, rr;
   int n_errors = 0, n_tests = 0, cyc = 0;
   assign obs = {pt, pa, gt, ga, et, ea, cmd};
   protection_alarm_trip_aggregator i_protection_alarm_trip_aggregator (
      .aclk(aclk), .aresetn(aresetn), .fault_criterion(fc),
      .fault_phase(fp), .trip_delay({E{16'h0004}}),
      .block_input_a(ba), .block_input_b(bb),
      .block_input_b_assigned(bas), .trip_block_input(tb),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .general_alarm(ga),
      .general_trip(gt), .phase_alarm(pa), .phase_trip(pt),
      .element_alarm(ea), .element_trip(et),
      .breaker_open_request(cmd));
   prot_far_side i_prot_far_side (.aclk(aclk), .fault_set(fault_set),
      .phase_set(phase_set), .fault_criterion(fc), .fault_phase(fp));
   initial forever #4 aclk = ~aclk;
   //////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] o(input logic [2:0] p_t, p_a,
      input logic g_t, g_a, input logic [7:0] e_t, e_a, c);
      return {p_t, p_a, g_t, g_a, e_t, e_a, c};
   endfunction
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [31:0] a, d);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (!bv);
      bry <= 0;
      chk(32'(br), {30'h0, a >= 32'h10, 1'b0});
   endtask
   task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
      @(posedge aclk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end while (!rv);
      rry <= 0;
      chk(rdat, ed);
      chk(32'(rr), 32'(er));
   endtask
   task automatic raise(input logic [7:0] f, input logic [23:0] p, int n);
      @(posedge aclk);
      fault_set <= f;
      phase_set <= p;
      repeat (n) @(posedge aclk);
   endtask
   //////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(32'h00, 32'h0, 2'b00);
      rd(32'h10, 32'h0, 2'b00);
      rd(32'h24, 32'h0, 2'b10);
      wr(32'h10, 32'h1);
      wr(32'h04, 32'h5a);
      rd(32'h04, 32'h5a, 2'b00);
      wr(32'h04, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_inactive;
      raise(8'h01, 24'h1, 16);
      chk(obs, 32'h0);
      raise(8'h00, 24'h0, 8);
      $display("test inactive done");
   endtask
   task automatic t_trip;
      wr(32'h00, 32'h1);
      wr(32'h08, 32'h1);
      // element 1 reports phase two but is not phase capable
      raise(8'h03, 24'h11, 6);
      chk(obs, o(3'h0, 3'h1, 0, 1, 8'h0, 8'h3, 8'h0));
      repeat (8) @(posedge aclk);
      chk(obs, o(3'h1, 3'h1, 1, 1, 8'h3, 8'h3, 8'h3));
      raise(8'h00, 24'h0, 8);
      chk(obs, 32'h0);
      $display("test trip done");
   endtask
   task automatic t_superv;
      wr(32'h04, 32'h2);
      wr(32'h08, 32'h3);
      raise(8'h03, 24'h0, 16);
      chk(obs, o(3'h0, 3'h0, 1, 1, 8'h3, 8'h3, 8'h1));
      // element 1 alone: phase capable, but supervision only
      raise(8'h02, 24'h10, 16);
      chk(obs, o(3'h0, 3'h0, 0, 0, 8'h2, 8'h2, 8'h0));
      raise(8'h00, 24'h0, 8);
      wr(32'h04, 32'h0);
      wr(32'h08, 32'h1);
      $display("test superv done");
   endtask
   task automatic bcase(logic [3:0] c, ins, logic pb, g, k);
      wr(32'h00, {28'h0, c});
      wr(32'h0c, {31'h0, pb});
      {ba, bb, bas, tb} <= ins;
      raise(8'h01, 24'h0, 16);
      chk(obs, o(3'h0, 3'h0, g, g, {7'h0, g}, {7'h0, g}, {7'h0, k}));
      raise(8'h00, 24'h0, 8);
      {ba, bb, bas, tb} <= 4'h0;
   endtask
   task automatic t_blocks;
      bcase(4'h3, 4'h8, 0, 0, 0);
      bcase(4'h1, 4'h8, 0, 1, 1);
      bcase(4'h3, 4'h4, 0, 1, 1);
      bcase(4'h3, 4'h6, 0, 0, 0);
      bcase(4'h5, 4'h0, 0, 1, 0);
      bcase(4'h9, 4'h1, 0, 1, 0);
      bcase(4'h1, 4'h1, 0, 1, 1);
      bcase(4'h1, 4'h0, 1, 1, 0);
      $display("test blocks done");
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_regs;
      t_inactive;
      t_trip;
      t_superv;
      t_blocks;
      end_sim;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_errors++;
         end_sim;
      end
   end
endmodule
bind protection_alarm_trip_aggregator prot_frame_asserts #(
   .ELEMENTS(ELEMENTS), .PHASES(PHASES)) i_prot_frame_asserts (
   .aclk(aclk), .aresetn(aresetn), .general_alarm(general_alarm),
   .general_trip(general_trip), .phase_alarm(phase_alarm),
   .phase_trip(phase_trip), .element_alarm(element_alarm),
   .element_trip(element_trip),
   .breaker_open_request(breaker_open_request));
